// ===== verilog/lce_pkg.sv
// Package for the load control event frame receiver.
// Assumes one 125 MHz clock; byte stream arrives from a UART-side framer.
package lce_pkg;

    // Byte offsets within the serial frame
    localparam logic [7:0] OFS_SUM_FIRST = 8'h03;
    localparam logic [7:0] OFS_TX_OPTS = 8'h16;
    localparam logic [7:0] OFS_FRAME_CTRL = 8'h17;
    localparam logic [7:0] OFS_MANUF_LO = 8'h18;
    localparam logic [7:0] OFS_EVENT_ID = 8'h1A;
    localparam logic [7:0] OFS_DEV_CLASS = 8'h1E;
    localparam logic [7:0] OFS_START_TIME = 8'h21;
    localparam logic [7:0] OFS_DURATION = 8'h25;
    localparam logic [7:0] OFS_CRITICALITY = 8'h27;
    localparam logic [7:0] OFS_COOL_OFFSET = 8'h28;
    localparam logic [7:0] OFS_HEAT_OFFSET = 8'h29;
    localparam logic [7:0] OFS_COOL_SETPT = 8'h2A;
    localparam logic [7:0] OFS_HEAT_SETPT = 8'h2C;
    localparam logic [7:0] OFS_LOAD_ADJ = 8'h2E;
    localparam logic [7:0] OFS_DUTY_CYCLE = 8'h2F;
    localparam logic [7:0] OFS_EVENT_CTRL = 8'h30;
    localparam logic [7:0] OFS_CHECKSUM = 8'h31;

    // Frame control bit positions
    localparam int FC_TYPE_LSB = 0;
    localparam int FC_MANUF_BIT = 2;
    localparam int FC_DIR_BIT = 3;
    localparam int FC_NO_DEFRSP_BIT = 4;
    localparam logic [1:0] FC_TYPE_CLUSTER = 2'h1;

    // "Not used" markers, start-now time and checksum base
    localparam logic [7:0] UNUSED_OFFSET = 8'hFF;
    localparam logic [15:0] UNUSED_SETPT = 16'h8000;
    localparam logic [7:0] UNUSED_LOAD_ADJ = 8'h80;
    localparam logic [7:0] UNUSED_DUTY = 8'hFF;
    localparam logic [31:0] START_NOW = 32'h0000_0000;
    localparam logic [7:0] CHECKSUM_BASE = 8'hFF;

    // APB register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
    localparam logic [7:0] ADDR_START = 8'h0C;
    localparam logic [7:0] ADDR_DUR_CRIT = 8'h10;
    localparam logic [7:0] ADDR_TEMPS = 8'h14;
    localparam logic [7:0] ADDR_SETPTS = 8'h18;
    localparam logic [7:0] ADDR_LIMITS = 8'h1C;
    localparam logic [7:0] ADDR_HEADER = 8'h20;
    localparam logic [7:0] ADDR_EVENT_ID = 8'h24;

    // Status bits: 0 frame ok, 1 checksum or transmit options error, 2 overrun
    localparam int NUM_EVENTS = 3;
    localparam logic [2:0] CTRL_RESET = 3'h1;

    // Decoded event payload
    typedef struct packed {
        logic [31:0] event_id;
        logic [15:0] dev_class;
        logic [31:0] start_time;
        logic [15:0] duration;
        logic [7:0] criticality;
        logic [7:0] cool_offset;
        logic [7:0] heat_offset;
        logic [15:0] cool_setpt;
        logic [15:0] heat_setpt;
        logic [7:0] load_adj;
        logic [7:0] duty_cycle;
        logic [7:0] event_ctrl;
        logic [7:0] frame_ctrl;
    } event_t;

    // Flags derived from the payload
    typedef struct packed {
        logic start_now;
        logic cool_off_used;
        logic heat_off_used;
        logic cool_sp_used;
        logic heat_sp_used;
        logic load_adj_used;
        logic duty_used;
        logic cluster_cmd;
        logic manuf_specific;
        logic server_to_client;
        logic default_rsp_off;
    } event_flags_t;

    // Serial byte input
    typedef struct packed {
        logic valid;
        logic first;
        logic [7:0] data;
    } byte_in_t;

endpackage

// ===== verilog/lce_checksum.sv
// Running checksum over one frame's bytes.
// Assumes the caller marks which bytes join the sum and when to clear it.
module lce_checksum
    import lce_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Byte stream
    input wire logic clear_i,
    input wire logic add_i,
    input wire logic [7:0] data_i,
    // Result
    output logic [7:0] expect_o
);

    typedef struct packed {
        logic [7:0] sum;
    } sum_state_t;

    sum_state_t state;
    sum_state_t next_state;

    // Sum wraps to eight bits by design
    always_comb begin
        next_state = state;
        if (clear_i) begin
            next_state.sum = 8'h00;
        end else if (add_i) begin
            next_state.sum = 8'(state.sum + data_i);
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Expected checksum byte
    assign expect_o = 8'(CHECKSUM_BASE - state.sum);

endmodule

// ===== verilog/lce_framer.sv
// Receiver for the tail of a load control event API frame.
// Assumes a byte stream from the serial front end on the same clock,
// and an APB master for software access.
//
// How it works
// - Cooling offset at 40, heating at 41; 0xFF marks unused.
// - Cooling set point 42..43, low first; 0x8000 marks unused.
// - Heating set point 44..45, low first; 0x8000 marks unused.
// - Load adjustment byte at 46; 0x80 means not applied.
// - Duty cycle byte at 47; 0xFF means no limit.
// - Checksum is 0xFF minus sum of bytes 3 up to checksum; verified.
// - Frame control bits 0..1 are frame type; 01 is cluster command.
// - Bit 2 marks manufacturer command; clear means no maker code.
// - Bit 3 set means server to client direction.
// - Bit 4 set disables default response.
// - Multi-byte payload fields arrive least significant byte first.
//
// The APB interface to the registers and the address map were decided locally.
module lce_framer
    import lce_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Serial byte stream, offset 0 flagged by first
    input wire logic byte_valid_i,
    input wire logic byte_first_i,
    input wire logic [7:0] byte_data_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Event result
    output logic event_valid_o,
    output event_t event_o,
    output event_flags_t flags_o,
    // Interrupt
    output logic irq_o
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BODY,
        ST_DONE
    } rx_state_t;

    typedef struct packed {
        rx_state_t fsm;
        logic [7:0] offset;
        event_t work;
        event_t held;
        event_flags_t flags;
        logic evt_pulse;
        logic opts_bad;
        logic [2:0] ctrl;
        logic [NUM_EVENTS-1:0] status;
        logic [NUM_EVENTS-1:0] mask;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic irq;
    } state_t;

    state_t state;
    state_t next_state;

    logic sum_clear;
    logic sum_add;
    logic [7:0] sum_expect;

    // Slot a byte into a little endian field at index idx
    function automatic logic [31:0] put_byte(input logic [31:0] word,
                                             input logic [1:0] idx,
                                             input logic [7:0] data);
        logic [31:0] w;
        w = word;
        w[idx*8 +: 8] = data;
        return w;
    endfunction

    // True when an offset falls in [base, base+len)
    function automatic logic in_field(input logic [7:0] ofs,
                                      input logic [7:0] base,
                                      input logic [7:0] len);
        return (ofs >= base) && (ofs < 8'(base + len));
    endfunction

    wire logic rx_enable = state.ctrl[0];
    wire logic apb_access = psel_i && penable_i && !state.ready;

    // Checksum covers offsets 3 through 48
    assign sum_clear = byte_valid_i && byte_first_i && rx_enable;
    assign sum_add = byte_valid_i && !byte_first_i && rx_enable &&
                     (state.offset >= OFS_SUM_FIRST) &&
                     (state.offset < OFS_CHECKSUM);

    lce_checksum u_sum (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .clear_i(sum_clear),
        .add_i(sum_add),
        .data_i(byte_data_i),
        .expect_o(sum_expect)
    );

    // Frame parse, register file and interrupt in one pass
    always_comb begin
        logic [NUM_EVENTS-1:0] ev;
        logic [7:0] ofs;
        logic [31:0] tmp;
        next_state = state;
        ev = '0;
        ofs = byte_first_i ? 8'h00 : state.offset;
        tmp = '0;
        next_state.evt_pulse = 1'b0;

        if (byte_valid_i && rx_enable) begin
            next_state.offset = 8'(ofs + 8'h01);
            if (byte_first_i) begin
                next_state.fsm = ST_BODY;
                next_state.opts_bad = 1'b0;
                next_state.work = '0;
            end
            if (state.fsm == ST_BODY || byte_first_i) begin
                if (ofs == OFS_TX_OPTS && byte_data_i != 8'h00) begin
                    next_state.opts_bad = 1'b1;
                end
                if (ofs == OFS_FRAME_CTRL) begin
                    // Reserved bits kept but never acted on
                    next_state.work.frame_ctrl = byte_data_i;
                end
                if (in_field(ofs, OFS_EVENT_ID, 8'd4)) begin
                    tmp = put_byte(state.work.event_id,
                                   2'(ofs - OFS_EVENT_ID), byte_data_i);
                    next_state.work.event_id = tmp;
                end
                if (in_field(ofs, OFS_DEV_CLASS, 8'd2)) begin
                    tmp = put_byte({16'h0000, state.work.dev_class},
                                   2'(ofs - OFS_DEV_CLASS), byte_data_i);
                    next_state.work.dev_class = tmp[15:0];
                end
                if (in_field(ofs, OFS_START_TIME, 8'd4)) begin
                    tmp = put_byte(state.work.start_time,
                                   2'(ofs - OFS_START_TIME), byte_data_i);
                    next_state.work.start_time = tmp;
                end
                if (in_field(ofs, OFS_DURATION, 8'd2)) begin
                    tmp = put_byte({16'h0000, state.work.duration},
                                   2'(ofs - OFS_DURATION), byte_data_i);
                    next_state.work.duration = tmp[15:0];
                end
                if (ofs == OFS_CRITICALITY) begin
                    next_state.work.criticality = byte_data_i;
                end
                if (ofs == OFS_COOL_OFFSET) begin
                    next_state.work.cool_offset = byte_data_i;
                end
                if (ofs == OFS_HEAT_OFFSET) begin
                    next_state.work.heat_offset = byte_data_i;
                end
                if (in_field(ofs, OFS_COOL_SETPT, 8'd2)) begin
                    tmp = put_byte({16'h0000, state.work.cool_setpt},
                                   2'(ofs - OFS_COOL_SETPT), byte_data_i);
                    next_state.work.cool_setpt = tmp[15:0];
                end
                if (in_field(ofs, OFS_HEAT_SETPT, 8'd2)) begin
                    tmp = put_byte({16'h0000, state.work.heat_setpt},
                                   2'(ofs - OFS_HEAT_SETPT), byte_data_i);
                    next_state.work.heat_setpt = tmp[15:0];
                end
                if (ofs == OFS_LOAD_ADJ) begin
                    next_state.work.load_adj = byte_data_i;
                end
                if (ofs == OFS_DUTY_CYCLE) begin
                    next_state.work.duty_cycle = byte_data_i;
                end
                if (ofs == OFS_EVENT_CTRL) begin
                    next_state.work.event_ctrl = byte_data_i;
                end
                if (ofs == OFS_CHECKSUM) begin
                    next_state.fsm = ST_DONE;
                    if (byte_data_i == sum_expect && !state.opts_bad) begin
                        // Good frame: publish and decode
                        ev[0] = 1'b1;
                        if (state.evt_pulse) begin
                            ev[2] = 1'b1;
                        end
                        next_state.evt_pulse = 1'b1;
                        next_state.held = state.work;
                        next_state.flags.start_now =
                            (state.work.start_time == START_NOW);
                        next_state.flags.cool_off_used =
                            (state.work.cool_offset != UNUSED_OFFSET);
                        next_state.flags.heat_off_used =
                            (state.work.heat_offset != UNUSED_OFFSET);
                        next_state.flags.cool_sp_used =
                            (state.work.cool_setpt != UNUSED_SETPT);
                        next_state.flags.heat_sp_used =
                            (state.work.heat_setpt != UNUSED_SETPT);
                        next_state.flags.load_adj_used =
                            (state.work.load_adj != UNUSED_LOAD_ADJ);
                        next_state.flags.duty_used =
                            (state.work.duty_cycle != UNUSED_DUTY);
                        next_state.flags.cluster_cmd =
                            (state.work.frame_ctrl[FC_TYPE_LSB +: 2] ==
                             FC_TYPE_CLUSTER);
                        next_state.flags.manuf_specific =
                            state.work.frame_ctrl[FC_MANUF_BIT];
                        next_state.flags.server_to_client =
                            state.work.frame_ctrl[FC_DIR_BIT];
                        next_state.flags.default_rsp_off =
                            state.work.frame_ctrl[FC_NO_DEFRSP_BIT];
                    end else begin
                        ev[1] = 1'b1;
                    end
                end
            end
        end

        // APB access: one wait state, then ready
        next_state.ready = 1'b0;
        next_state.slverr = 1'b0;
        if (apb_access) begin
            next_state.ready = 1'b1;
            next_state.rdata = 32'h0000_0000;
            case (paddr_i)
                ADDR_CTRL: begin
                    next_state.rdata = {29'h0, state.ctrl};
                    if (pwrite_i) begin
                        next_state.ctrl = pwdata_i[2:0];
                    end
                end
                ADDR_STATUS: begin
                    next_state.rdata = {29'h0, state.status};
                end
                ADDR_IRQ_MASK: begin
                    next_state.rdata = {29'h0, state.mask};
                    if (pwrite_i) begin
                        next_state.mask = pwdata_i[NUM_EVENTS-1:0];
                    end
                end
                ADDR_START: next_state.rdata = state.held.start_time;
                ADDR_DUR_CRIT: begin
                    next_state.rdata = {8'h00, state.held.criticality,
                                        state.held.duration};
                end
                ADDR_TEMPS: begin
                    next_state.rdata = {16'h0000, state.held.heat_offset,
                                        state.held.cool_offset};
                end
                ADDR_SETPTS: begin
                    next_state.rdata = {state.held.heat_setpt,
                                        state.held.cool_setpt};
                end
                ADDR_LIMITS: begin
                    next_state.rdata = {8'h00, state.held.event_ctrl,
                                        state.held.duty_cycle,
                                        state.held.load_adj};
                end
                ADDR_HEADER: begin
                    next_state.rdata = {8'h00, state.held.frame_ctrl,
                                        state.held.dev_class};
                end
                ADDR_EVENT_ID: next_state.rdata = state.held.event_id;
                default: begin
                    next_state.slverr = 1'b1;
                end
            endcase
        end

        // Sticky status: write one clears, a new event wins over clear
        if (apb_access && pwrite_i && paddr_i == ADDR_STATUS) begin
            next_state.status = state.status & ~pwdata_i[NUM_EVENTS-1:0];
        end
        next_state.status = next_state.status | ev;
        next_state.irq = |(next_state.status & next_state.mask);
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= '0;
            state.fsm <= ST_IDLE;
            state.ctrl <= CTRL_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from state
    assign prdata_o = state.rdata;
    assign pready_o = state.ready;
    assign pslverr_o = state.slverr;
    assign event_valid_o = state.evt_pulse;
    assign event_o = state.held;
    assign flags_o = state.flags;
    assign irq_o = state.irq;

endmodule

// ===== tb/lce_framer_checker.sv
// Concurrent checks on the framer's decoded event outputs.
// Assumes binding to lce_framer; sees only its ports.
module lce_framer_checker
    import lce_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Watched outputs
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic event_valid_o,
    input wire event_t event_o,
    input wire event_flags_t flags_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Flags other than cool_off_used must agree with the event they arrive with
    start_now_a:
        assert property (event_valid_o |-> flags_o.start_now ==
            (event_o.start_time == 32'h0000_0000)) else $error("start flag");
    ofs_used_a:
        assert property (event_valid_o |-> flags_o.heat_off_used ==
            (event_o.heat_offset != 8'hFF)) else $error("offset flag");
    cool_sp_a:
        assert property (event_valid_o |-> flags_o.cool_sp_used ==
            (event_o.cool_setpt != 16'h8000)) else $error("cool sp flag");
    heat_sp_a:
        assert property (event_valid_o |-> flags_o.heat_sp_used ==
            (event_o.heat_setpt != 16'h8000)) else $error("heat sp flag");
    load_adj_a:
        assert property (event_valid_o |-> flags_o.load_adj_used ==
            (event_o.load_adj != 8'h80)) else $error("load adj flag");
    duty_used_a:
        assert property (event_valid_o |-> flags_o.duty_used ==
            (event_o.duty_cycle != 8'hFF)) else $error("duty flag");
    frame_type_a:
        assert property (event_valid_o |-> flags_o.cluster_cmd ==
            (event_o.frame_ctrl[1:0] == 2'h1)) else $error("frame type");
    manuf_bit_a:
        assert property (event_valid_o |-> flags_o.manuf_specific ==
            event_o.frame_ctrl[2]) else $error("maker flag");
    dir_bit_a:
        assert property (event_valid_o |-> flags_o.server_to_client ==
            event_o.frame_ctrl[3]) else $error("direction flag");
    def_rsp_a:
        assert property (event_valid_o |-> flags_o.default_rsp_off ==
            event_o.frame_ctrl[4]) else $error("default rsp flag");
    // Only an accepted frame may disturb the held result
    event_hold_a:
        assert property (!event_valid_o |=> event_valid_o ||
            ($stable(event_o) && $stable(flags_o))) else $error("event moved");
    pulse_once_a:
        assert property (event_valid_o |=> !event_valid_o [*3])
            else $error("event pulse long");

    // Main scenarios reached
    cover property (event_valid_o && flags_o.cluster_cmd);
    cover property ($rose(irq_o));
    cover property (pready_o && pslverr_o);
endmodule

bind lce_framer lce_framer_checker chk_u (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .event_valid_o(event_valid_o),
    .event_o(event_o),
    .flags_o(flags_o),
    .irq_o(irq_o)
);

// ===== tb/lce_host_model.sv
// Host controller model: sends one API frame byte by byte.
// Assumes the caller fills offsets 0..48 and calls just after a clock edge.
module lce_host_model
(
    // Clock
    input wire logic clk_i,
    // Byte stream toward the framer
    output logic valid_o,
    output logic first_o,
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle line at time zero
    initial begin
        valid_o = 1'b0;
        first_o = 1'b0;
        data_o = 8'h00;
    end

    // Gap idle cycles between bytes; bad spoils the checksum on purpose
    task automatic send(input logic [7:0] f [50], input int gap,
        input bit bad);
        logic [7:0] sum;
        sum = 8'h00;
        f[22] = 8'h00;
        f[23][7:5] = 3'h0;
        for (int i = 3; i < 49; i++) begin
            sum = sum + f[i];
        end
        f[49] = (8'hFF - sum) ^ {7'h00, bad};
        for (int i = 0; i < 50; i++) begin
            valid_o <= 1'b1;
            first_o <= (i == 0);
            data_o <= f[i];
            @(posedge clk_i);
            if (gap > 0) begin
                // Stale data inverted so nothing leans on a held byte
                valid_o <= 1'b0;
                first_o <= 1'b0;
                data_o <= ~f[i];
                repeat (gap) @(posedge clk_i);
            end
        end
        valid_o <= 1'b0;
        first_o <= 1'b0;
        data_o <= ~f[49];
        @(posedge clk_i);
    endtask
endmodule

// ===== tb/lce_framer_tb.sv
// Self-checking bench for the load control event framer.
// Assumes the checker binds itself; host model feeds the byte stream.
module lce_framer_tb;
    import lce_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i, nrst_i, psel, penable, pwrite, pready, pslverr;
    logic ev_valid, irq, bvalid, bfirst;
    logic [7:0] paddr, bdata;
    logic [31:0] pwdata, prdata;
    event_t ev_o, ev_m, e;
    event_flags_t fl_o;
    event_t exp_q[$];
    int n_fail = 0;
    int comparisons = 0;
    logic [31:0] seed = 32'h17e8_284d;

    lce_framer dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
        .byte_valid_i(bvalid), .byte_first_i(bfirst), .byte_data_i(bdata),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .event_valid_o(ev_valid),
        .event_o(ev_o), .flags_o(fl_o), .irq_o(irq));
    lce_host_model host_u (.clk_i(clk_i), .valid_o(bvalid),
        .first_o(bfirst), .data_o(bdata));

    // 125 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic check(input string what, input logic [191:0] seen,
        input logic [191:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Random event; set bits of m force start now and the unused markers
    function automatic event_t rnd(input logic [31:0] m);
        logic [191:0] r;
        r = {xs(), xs(), xs(), xs(), xs(), xs()};
        rnd = r[183:0];
        rnd.frame_ctrl[7:5] = 3'h0;
        if (m[0]) rnd.start_time = 32'h0000_0000;
        if (m[1]) rnd.cool_offset = 8'hFF;
        if (m[2]) rnd.heat_offset = 8'hFF;
        if (m[3]) rnd.cool_setpt = 16'h8000;
        if (m[4]) rnd.heat_setpt = 16'h8000;
        if (m[5]) rnd.load_adj = 8'h80;
        if (m[6]) rnd.duty_cycle = 8'hFF;
    endfunction

    // Expected flags, worked out independently of the design
    function automatic event_flags_t flags_of(input event_t x);
        flags_of.start_now = x.start_time == 32'h0000_0000;
        flags_of.cool_off_used = x.cool_offset != 8'hFF;
        flags_of.heat_off_used = x.heat_offset != 8'hFF;
        flags_of.cool_sp_used = x.cool_setpt != 16'h8000;
        flags_of.heat_sp_used = x.heat_setpt != 16'h8000;
        flags_of.load_adj_used = x.load_adj != 8'h80;
        flags_of.duty_used = x.duty_cycle != 8'hFF;
        flags_of.cluster_cmd = x.frame_ctrl[1:0] == 2'h1;
        flags_of.manuf_specific = x.frame_ctrl[2];
        flags_of.server_to_client = x.frame_ctrl[3];
        flags_of.default_rsp_off = x.frame_ctrl[4];
    endfunction

    // Frame bytes; header filler random, payload little endian
    task automatic frame(input event_t x, input int gap, input bit bad,
        input bit want);
        logic [7:0] f [50];
        for (int i = 0; i < 50; i++) begin
            f[i] = 8'(xs());
        end
        f[0] = 8'h7E;
        f[23] = x.frame_ctrl;
        {f[29], f[28], f[27], f[26]} = x.event_id;
        {f[31], f[30]} = x.dev_class;
        {f[36], f[35], f[34], f[33]} = x.start_time;
        {f[38], f[37]} = x.duration;
        f[39] = x.criticality;
        {f[41], f[40]} = {x.heat_offset, x.cool_offset};
        {f[43], f[42]} = x.cool_setpt;
        {f[45], f[44]} = x.heat_setpt;
        {f[48], f[47], f[46]} = {x.event_ctrl, x.duty_cycle, x.load_adj};
        if (want) exp_q.push_back(x);
        host_u.send(f, gap, bad);
        repeat (3) @(posedge clk_i);
    endtask

    // One APB transfer; pready and read data taken at the rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        check("pready", n < 50, 1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
        input logic eerr);
        logic [31:0] d;
        logic er;
        apb(1'b0, a, 32'h0000_0000, d, er);
        check("prdata", d, exp);
        check("pslverr", er, eerr);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dd;
        logic er;
        apb(1'b1, a, d, dd, er);
        check("pslverr", er, 1'b0);
    endtask

    task automatic irq_is(input logic exp);
        @(negedge clk_i);
        check("irq", irq, exp);
        @(posedge clk_i);
    endtask

    // Watches results and pairs each with the oldest expectation
    always @(negedge clk_i) begin
        if (nrst_i === 1'b1 && ev_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected event", 1, 0);
            end else begin
                ev_m = exp_q.pop_front();
                check("event", ev_o, ev_m);
                check("flags", fl_o, flags_of(ev_m));
            end
        end
    end

    // Watchdog well beyond the expected run
    initial begin
        repeat (30000) @(posedge clk_i);
        n_fail++;
        results();
    end

    initial begin
        {nrst_i, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        // Reset values and an unmapped address
        rd(ADDR_CTRL, 32'h0000_0001, 1'b0);
        rd(ADDR_IRQ_MASK, 32'h0000_0000, 1'b0);
        rd(8'h40, 32'h0000_0000, 1'b1);
        wr(ADDR_IRQ_MASK, 32'h0000_0003);
        // Every optional field unused, start now
        e = rnd(32'hFFFF_FFFF);
        e.frame_ctrl = 8'h09;
        frame(e, 2, 1'b0, 1'b1);
        irq_is(1'b1);
        rd(ADDR_STATUS, 32'h0000_0001, 1'b0);
        wr(ADDR_STATUS, 32'h0000_0001);
        irq_is(1'b0);
        // All frame types, tight and spaced byte timing
        for (int k = 0; k < 12; k++) begin
            e = rnd(xs());
            e.frame_ctrl[1:0] = k[1:0];
            frame(e, k % 3, 1'b0, 1'b1);
        end
        rd(ADDR_SETPTS, {e.heat_setpt, e.cool_setpt}, 1'b0);
        rd(ADDR_START, e.start_time, 1'b0);
        // Spoiled checksum gives no event, only the error bit
        wr(ADDR_STATUS, 32'h0000_0007);
        frame(rnd(xs()), 1, 1'b1, 1'b0);
        rd(ADDR_STATUS, 32'h0000_0002, 1'b0);
        irq_is(1'b1);
        wr(ADDR_STATUS, 32'h0000_0002);
        // Receiver off ignores a frame, then recovers
        wr(ADDR_CTRL, 32'h0000_0000);
        frame(rnd(xs()), 0, 1'b0, 1'b0);
        wr(ADDR_CTRL, 32'h0000_0001);
        frame(rnd(xs()), 0, 1'b0, 1'b1);
        check("pending events", exp_q.size(), 0);
        results();
    end
endmodule
